// ### core/sct_top.sv
// Purpose: Passive bus capture buffer with configurable trigger and qualifier
// Assumes: Bus pins are asynchronous, 1 = asserted; Avalon-MM slave on sys_clk
// Notes: While clk_en is high every read takes one wait state and writes take none
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
module sct_top (
	input logic sys_clk, // 40 MHz clock
	input logic rst_b, // Sync reset, active low
	input logic clk_en, // Freezes all state when low
	input logic [3:0] avs_address, // Register word index
	input logic avs_read, // Read request
	input logic avs_write, // Write request
	input logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall the master
	input logic [8:0] scsi_ctl_in, // BSY SEL ATN REQ ACK C/D I/O MSG RST
	input logic [8:0] scsi_dat_in, // Parity line then D7..D0
	output logic irq // Level interrupt
);
	logic [17:0] sync1_ff;
	logic [17:0] sync2_ff;
	sct_pkg::sct_cfg_t cfg_ff;
	sct_pkg::sct_cfg_t nxt_cfg;
	sct_pkg::sct_cfg_t act_ff;
	sct_pkg::sct_cap_t cap_ff;
	sct_pkg::sct_cap_t nxt_cap;
	sct_pkg::sct_phase_t phase_q_ff;
	logic [sct_pkg::EW-1:0] buf_mem_ff [sct_pkg::DEPTH];
	logic [sct_pkg::AW-1:0] wp_ff;
	logic [sct_pkg::AW:0] len_ff;
	logic [sct_pkg::AW:0] post_ff;
	logic [sct_pkg::AW-1:0] trig_pos_ff;
	logic [sct_pkg::AW-1:0] rd_ptr_ff;
	logic [sct_pkg::TKW-1:0] tick_ff;
	logic [sct_pkg::TSW-1:0] ts_ff;
	logic [15:0] bcnt_ff;
	logic [sct_pkg::IRQW-1:0] irq_st_ff;
	logic [sct_pkg::IRQW-1:0] irq_mask_ff;
	logic [31:0] rdata_ff;
	logic rd_ack_ff;
	logic trig_ff;
	logic mark_pend_ff;
	logic start_ff;
	logic wr_en;
	logic wr_ctrl;
	logic wr_tt;
	logic wr_pat;
	logic wr_cnt;
	logic wr_pl;
	logic wr_qm;
	logic wr_ql;
	logic wr_badr;
	logic wr_mask;
	logic start_req;
	logic stop_req;
	logic trig_bad;
	logic qual_bad;
	logic rd_go;
	logic rd_take;
	logic running;
	logic armed;
	logic hit;
	logic mark_now;
	logic in_data;
	logic new_ph;
	logic over;
	logic qual_ok;
	logic store;
	logic done;
	logic [15:0] bcnt_eff;
	logic [sct_pkg::AW:0] quota;
	logic [sct_pkg::AW-1:0] oldest;
	logic [1:0] status;
	logic [sct_pkg::IRQW-1:0] irq_set;
	logic [sct_pkg::IRQW-1:0] irq_clr;
	logic [sct_pkg::EW-1:0] rd_word;
	logic [31:0] rd_mux;

	// Register select, shared by the write and read paths
	function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
		is_reg = (a == r);
	endfunction

	// Storage allowed per qualifier mode and phase
	function automatic logic q_allow(input logic [1:0] m, input sct_pkg::sct_phase_t p);
		logic base;
		base = (p == sct_pkg::ph_bus_free) || (p == sct_pkg::ph_arbitration) ||
			(p == sct_pkg::ph_selection) || (p == sct_pkg::ph_reselection);
		q_allow = (m == sct_pkg::QM_ALL) || base ||
			((p == sct_pkg::ph_command) && (m != sct_pkg::store_arb_select_only)) ||
			((p == sct_pkg::ph_status) && (m == sct_pkg::store_arb_select_command_status));
	endfunction

	// Two-stage synchroniser for the bus pins
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else if (clk_en) begin
			sync1_ff <= {scsi_ctl_in, scsi_dat_in};
			sync2_ff <= sync1_ff;
		end
	end

	// Decoder and trigger matcher
	sct_bus_if bus ();
	assign bus.ctl = sync2_ff[17:9];
	assign bus.dat = sync2_ff[8:0];

	sct_phase_dec u_dec (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.bus(bus)
	);

	sct_trig u_trig (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.bus(bus),
		.start(start_ff),
		.armed(armed),
		.cfg(act_ff),
		.hit(hit)
	);

	// Bus slave decode; a read costs one wait state to fetch buffer data
	assign wr_en = avs_write && clk_en;
	assign wr_ctrl = wr_en && is_reg(avs_address, sct_pkg::REG_CTRL);
	assign wr_tt = wr_en && is_reg(avs_address, sct_pkg::REG_TTYPE);
	assign wr_pat = wr_en && is_reg(avs_address, sct_pkg::REG_TPAT);
	assign wr_cnt = wr_en && is_reg(avs_address, sct_pkg::REG_TCOUNT);
	assign wr_pl = wr_en && is_reg(avs_address, sct_pkg::REG_TPLACE);
	assign wr_qm = wr_en && is_reg(avs_address, sct_pkg::REG_QMODE);
	assign wr_ql = wr_en && is_reg(avs_address, sct_pkg::REG_QLIMIT);
	assign wr_badr = wr_en && is_reg(avs_address, sct_pkg::REG_BUF_ADDR);
	assign wr_mask = wr_en && is_reg(avs_address, sct_pkg::REG_IRQ_MASK);
	assign start_req = wr_ctrl && avs_writedata[sct_pkg::CTL_START];
	assign stop_req = wr_ctrl && avs_writedata[sct_pkg::CTL_STOP];
	assign rd_go = avs_read && !rd_ack_ff;
	assign rd_take = avs_read && rd_ack_ff && clk_en;
	assign avs_waitrequest = !clk_en || rd_go;
	assign avs_readdata = rdata_ff;

	// Range checks on settings writes
	assign trig_bad = (wr_tt && (avs_writedata > 32'(sct_pkg::TT_MIN))) ||
		(wr_pat && ((|(avs_writedata[sct_pkg::PAT_VAL_LSB +: sct_pkg::PW] & ~avs_writedata[sct_pkg::PW-1:0])) ||
		(|(avs_writedata & ~32'h01FF01FF)))) ||
		(wr_cnt && (|avs_writedata[31:16])) ||
		(wr_pl && (avs_writedata > 32'(sct_pkg::PL_AFTER)));
	assign qual_bad = (wr_qm && (avs_writedata > 32'(sct_pkg::store_arb_select_command_status))) ||
		(wr_ql && ((avs_writedata == 32'h00000000) || (avs_writedata > 32'(sct_pkg::LIMIT_MAX))));

	// Staged settings; a bad write resets its whole group
	always_comb begin
		nxt_cfg = cfg_ff;
		if (wr_tt) begin
			nxt_cfg.tt = avs_writedata[3:0];
		end
		if (wr_pat) begin
			nxt_cfg.care = avs_writedata[sct_pkg::PW-1:0];
			nxt_cfg.val = avs_writedata[sct_pkg::PAT_VAL_LSB +: sct_pkg::PW];
		end
		if (wr_cnt) begin
			nxt_cfg.cnt = avs_writedata[15:0];
		end
		if (wr_pl) begin
			nxt_cfg.place = avs_writedata[1:0];
		end
		if (wr_qm) begin
			nxt_cfg.qmode = avs_writedata[1:0];
		end
		if (wr_ql) begin
			nxt_cfg.limit = avs_writedata[15:0];
		end
		if (trig_bad) begin
			nxt_cfg.tt = sct_pkg::CFG_DEF.tt;
			nxt_cfg.care = sct_pkg::CFG_DEF.care;
			nxt_cfg.val = sct_pkg::CFG_DEF.val;
			nxt_cfg.cnt = sct_pkg::CFG_DEF.cnt;
			nxt_cfg.place = sct_pkg::CFG_DEF.place;
		end
		if (qual_bad) begin
			nxt_cfg.qmode = sct_pkg::CFG_DEF.qmode;
			nxt_cfg.limit = sct_pkg::CFG_DEF.limit;
		end
	end

	// Qualifier and per-phase byte limit
	assign in_data = (bus.phase == sct_pkg::ph_data_out) || (bus.phase == sct_pkg::ph_data_in);
	assign new_ph = bus.phase != phase_q_ff;
	assign bcnt_eff = new_ph ? 16'h0000 : bcnt_ff;
	assign over = (act_ff.qmode == sct_pkg::QM_ALL) && in_data && (bcnt_eff >= act_ff.limit);
	assign qual_ok = q_allow(act_ff.qmode, bus.phase) && !over;

	// Capture control
	assign running = cap_ff == sct_pkg::cap_run;
	assign armed = running && !trig_ff;
	assign mark_now = hit || mark_pend_ff;
	assign store = running && bus.chg && qual_ok;
	assign quota = (act_ff.place == sct_pkg::PL_CENTER) ? sct_pkg::Q_CENTER :
		(act_ff.place == sct_pkg::PL_AFTER) ? sct_pkg::Q_AFTER : sct_pkg::Q_BEFORE;
	assign done = store && (trig_ff || hit) && ((post_ff + 1'b1) >= quota);

	// Capture state; a stop request beats a filling buffer
	always_comb begin
		nxt_cap = cap_ff;
		unique case (cap_ff)
			sct_pkg::cap_idle, sct_pkg::cap_full: begin
				if (start_req) begin
					nxt_cap = sct_pkg::cap_run;
				end
			end
			sct_pkg::cap_run: begin
				if (start_req) begin
					nxt_cap = sct_pkg::cap_run;
				end else if (stop_req) begin
					nxt_cap = sct_pkg::cap_idle;
				end else if (done) begin
					nxt_cap = sct_pkg::cap_full;
				end
			end
		endcase
	end

	// Status code and interrupt events
	assign status = (cap_ff == sct_pkg::cap_idle) ? sct_pkg::ST_IDLE :
		(cap_ff == sct_pkg::cap_full) ? sct_pkg::ST_FULL :
		trig_ff ? sct_pkg::ST_TRIG : sct_pkg::ST_WAIT;
	assign irq_set = {(running && nxt_cap == sct_pkg::cap_full), hit};
	assign irq_clr = (rd_take && is_reg(avs_address, sct_pkg::REG_IRQ_ST)) ? rdata_ff[sct_pkg::IRQW-1:0] : '0;
	assign irq = |(irq_st_ff & irq_mask_ff);

	// Oldest entry once the ring has wrapped
	assign oldest = len_ff[sct_pkg::AW] ? wp_ff : '0;
	assign rd_word = buf_mem_ff[rd_ptr_ff];

	// Read data select
	always_comb begin
		unique case (avs_address)
			sct_pkg::REG_STATUS: rd_mux = 32'(status);
			sct_pkg::REG_TTYPE: rd_mux = 32'(cfg_ff.tt);
			sct_pkg::REG_TPAT: rd_mux = (32'(cfg_ff.val) << sct_pkg::PAT_VAL_LSB) | 32'(cfg_ff.care);
			sct_pkg::REG_TCOUNT: rd_mux = 32'(cfg_ff.cnt);
			sct_pkg::REG_TPLACE: rd_mux = 32'(cfg_ff.place);
			sct_pkg::REG_QMODE: rd_mux = 32'(cfg_ff.qmode);
			sct_pkg::REG_QLIMIT: rd_mux = 32'(cfg_ff.limit);
			sct_pkg::REG_BUF_ADDR: rd_mux = 32'(rd_ptr_ff);
			sct_pkg::REG_BUF_LO: rd_mux = 32'(rd_word[sct_pkg::EW-sct_pkg::TSW-1:0]);
			sct_pkg::REG_BUF_HI: rd_mux = 32'(rd_word[sct_pkg::EW-1 -: sct_pkg::TSW]);
			sct_pkg::REG_LOG: rd_mux = (32'(oldest) << sct_pkg::LOG_OLD_LSB) | 32'(len_ff);
			sct_pkg::REG_TPOS: rd_mux = 32'(trig_pos_ff);
			sct_pkg::REG_IRQ_ST: rd_mux = 32'(irq_st_ff);
			sct_pkg::REG_IRQ_MASK: rd_mux = 32'(irq_mask_ff);
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Bus slave and software-visible registers
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg_ff <= sct_pkg::CFG_DEF;
			rd_ack_ff <= 1'b0;
			rdata_ff <= '0;
			rd_ptr_ff <= '0;
			irq_mask_ff <= '0;
			irq_st_ff <= '0;
		end else if (clk_en) begin
			cfg_ff <= nxt_cfg;
			rd_ack_ff <= rd_go;
			if (rd_go) begin
				rdata_ff <= rd_mux;
			end
			if (wr_badr) begin
				rd_ptr_ff <= avs_writedata[sct_pkg::AW-1:0];
			end
			if (wr_mask) begin
				irq_mask_ff <= avs_writedata[sct_pkg::IRQW-1:0];
			end
			irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set; // New events win over the clear
		end
	end

	// Capture sequencing; settings are copied only when a capture starts
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			act_ff <= sct_pkg::CFG_DEF;
			cap_ff <= sct_pkg::cap_idle;
			start_ff <= 1'b0;
			trig_ff <= 1'b0;
			mark_pend_ff <= 1'b0;
			trig_pos_ff <= '0;
		end else if (clk_en) begin
			cap_ff <= nxt_cap;
			start_ff <= start_req;
			if (start_req) begin
				act_ff <= cfg_ff;
				trig_ff <= 1'b0;
				mark_pend_ff <= 1'b0;
			end else begin
				trig_ff <= trig_ff || hit;
				mark_pend_ff <= mark_now && !store;
				if (store && mark_now) begin
					trig_pos_ff <= wp_ff;
				end
			end
		end
	end

	// Buffer pointers and the 100 ns timestamp
	always_ff @(posedge sys_clk) begin
		if (!rst_b || (clk_en && start_req)) begin
			wp_ff <= '0;
			len_ff <= '0;
			post_ff <= '0;
			tick_ff <= '0;
			ts_ff <= '0;
		end else if (clk_en) begin
			tick_ff <= (tick_ff == sct_pkg::TKW'(sct_pkg::TICK_CYC - 1)) ? '0 : tick_ff + 1'b1;
			if (tick_ff == sct_pkg::TKW'(sct_pkg::TICK_CYC - 1)) begin
				ts_ff <= ts_ff + 1'b1; // Wraps; software unwraps deltas
			end
			if (store) begin
				wp_ff <= wp_ff + 1'b1; // Ring: pre-trigger history overwrites itself
				len_ff <= len_ff[sct_pkg::AW] ? len_ff : len_ff + 1'b1;
				post_ff <= (trig_ff || hit) ? post_ff + 1'b1 : post_ff;
			end
		end
	end

	// Phase tracker for the byte limit
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			phase_q_ff <= sct_pkg::ph_bus_free;
			bcnt_ff <= '0;
		end else if (clk_en) begin
			phase_q_ff <= bus.phase;
			bcnt_ff <= (bus.byte_stb && in_data && bcnt_eff != '1) ? bcnt_eff + 1'b1 : bcnt_eff;
		end
	end

	// Event memory, no reset needed
	always_ff @(posedge sys_clk) begin
		if (clk_en && store && rst_b) begin
			buf_mem_ff[wp_ff] <= {ts_ff, mark_now, bus.ctl, bus.dat};
		end
	end
endmodule

// ### core/sct_pkg.sv
// Purpose: Shared constants and types for the bus capture and trigger block
// Assumes: 40 MHz sys_clk, register word indices on a 4-bit Avalon address
// Notes: Byte address of a register is four times its index
package sct_pkg;
	// Capture buffer geometry
	localparam int DEPTH = 1024;
	localparam int AW = 10;
	localparam int PW = 9;
	localparam int TSW = 16;
	localparam int EW = TSW + 1 + 2 * PW;
	// Timestamp tick of 100 ns derived from the clock rate
	localparam int CLK_KHZ = 40000;
	localparam int TICK_NS = 100;
	localparam int TICK_CYC = (TICK_NS * CLK_KHZ) / 1000000;
	localparam int TKW = 3;
	// Post-trigger share of the buffer per placement
	localparam int POST_PCT = 95;
	localparam logic [AW:0] Q_BEFORE = (AW + 1)'(DEPTH * POST_PCT / 100);
	localparam logic [AW:0] Q_CENTER = (AW + 1)'(DEPTH / 2);
	localparam logic [AW:0] Q_AFTER = (AW + 1)'(DEPTH - DEPTH * POST_PCT / 100);
	// Register word indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_TTYPE = 4'h2;
	localparam logic [3:0] REG_TPAT = 4'h3;
	localparam logic [3:0] REG_TCOUNT = 4'h4;
	localparam logic [3:0] REG_TPLACE = 4'h5;
	localparam logic [3:0] REG_QMODE = 4'h6;
	localparam logic [3:0] REG_QLIMIT = 4'h7;
	localparam logic [3:0] REG_BUF_ADDR = 4'h8;
	localparam logic [3:0] REG_BUF_LO = 4'h9;
	localparam logic [3:0] REG_BUF_HI = 4'hA;
	localparam logic [3:0] REG_LOG = 4'hB;
	localparam logic [3:0] REG_TPOS = 4'hC;
	localparam logic [3:0] REG_IRQ_ST = 4'hD;
	localparam logic [3:0] REG_IRQ_MASK = 4'hE;
	// Field positions
	localparam int CTL_START = 0;
	localparam int CTL_STOP = 1;
	localparam int PAT_VAL_LSB = 16;
	localparam int LOG_OLD_LSB = 16;
	localparam int IRQ_TRIG = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQW = 2;
	// Control line positions, 1 = asserted
	localparam int CB_BSY = 8;
	localparam int CB_SEL = 7;
	localparam int CB_ACK = 4;
	localparam int CB_CD = 3;
	localparam int CB_IO = 2;
	localparam int CB_MSG = 1;
	// Trigger types
	localparam logic [3:0] TT_NONE = 4'h0;
	localparam logic [3:0] TT_IMMED = 4'h1;
	localparam logic [3:0] TT_ARB = 4'h2;
	localparam logic [3:0] TT_SEL = 4'h3;
	localparam logic [3:0] TT_RESEL = 4'h4;
	localparam logic [3:0] TT_MOUT = 4'h5;
	localparam logic [3:0] TT_CMD = 4'h6;
	localparam logic [3:0] TT_DOUT = 4'h7;
	localparam logic [3:0] TT_DIN = 4'h8;
	localparam logic [3:0] TT_STAT = 4'h9;
	localparam logic [3:0] TT_MIN = 4'hA;
	// Placements
	localparam logic [1:0] PL_BEFORE = 2'h0;
	localparam logic [1:0] PL_CENTER = 2'h1;
	localparam logic [1:0] PL_AFTER = 2'h2;
	// Qualifier modes and byte limit
	localparam logic [1:0] QM_ALL = 2'h0;
	localparam logic [1:0] store_arb_select_only = 2'h1;
	localparam logic [1:0] store_arb_select_command = 2'h2;
	localparam logic [1:0] store_arb_select_command_status = 2'h3;
	localparam logic [15:0] LIMIT_DEF = 16'h8000;
	localparam logic [15:0] LIMIT_MAX = 16'hEFFF;
	localparam logic [15:0] COUNT_DEF = 16'h0001;
	// Status codes
	localparam logic [1:0] ST_WAIT = 2'h0;
	localparam logic [1:0] ST_TRIG = 2'h1;
	localparam logic [1:0] ST_FULL = 2'h2;
	localparam logic [1:0] ST_IDLE = 2'h3;
	// Information phase codes of {MSG, C/D, I/O}
	localparam logic [2:0] IP_DOUT = 3'h0;
	localparam logic [2:0] IP_DIN = 3'h1;
	localparam logic [2:0] IP_CMD = 3'h2;
	localparam logic [2:0] IP_STAT = 3'h3;
	localparam logic [2:0] IP_MOUT = 3'h6;
	localparam logic [2:0] IP_MIN = 3'h7;
	typedef enum logic [3:0] {
		ph_bus_free, ph_arbitration, ph_selection, ph_reselection, ph_data_out, ph_data_in,
		ph_command, ph_status, message_out_phase, message_in_phase, ph_reserved
	} sct_phase_t;
	typedef enum logic [1:0] {cap_idle, cap_run, cap_full} sct_cap_t;
	typedef struct packed {
		logic [3:0] tt;
		logic [PW-1:0] care;
		logic [PW-1:0] val;
		logic [15:0] cnt;
		logic [1:0] place;
		logic [1:0] qmode;
		logic [15:0] limit;
	} sct_cfg_t;
	localparam sct_cfg_t CFG_DEF = '{tt: TT_IMMED, care: 9'h000, val: 9'h000, cnt: COUNT_DEF,
		place: PL_BEFORE, qmode: QM_ALL, limit: LIMIT_DEF};
endpackage

// ### core/sct_bus_if.sv
// Purpose: Decoded bus view shared by the capture modules
// Assumes: All members are on sys_clk
// Notes: The top drives the synchronised lines, the decoder the rest
`timescale 1ns/1ps
interface sct_bus_if;
	logic [8:0] ctl;
	logic [8:0] dat;
	logic chg;
	logic byte_stb;
	logic arb_start;
	logic sel_start;
	logic resel_start;
	sct_pkg::sct_phase_t phase;
	modport top (output ctl, output dat, input chg, input byte_stb, input phase);
	modport dec (input ctl, input dat, output chg, output byte_stb, output arb_start,
		output sel_start, output resel_start, output phase);
	modport trg (input dat, input byte_stb, input arb_start, input sel_start, input resel_start,
		input phase);
endinterface

// ### core/sct_phase_dec.sv
// Purpose: Bus phase decoder and line change detector
// Assumes: Lines are already synchronised to sys_clk
// Notes: Arbitration is BSY alone after a bus free, until SEL drops
`timescale 1ns/1ps
module sct_phase_dec (
	input logic sys_clk, // System clock
	input logic rst_b, // Sync reset, active low
	input logic clk_en, // Freezes state when low
	sct_bus_if.dec bus // Decoded bus view
);
	logic [17:0] prev_ff;
	logic arb_win_ff;
	sct_pkg::sct_phase_t prev_ph_ff;
	sct_pkg::sct_phase_t cur_ph;
	logic bsy;
	logic sel;
	logic io;
	logic nxt_arb_win;

	// Information phase from MSG, C/D, I/O
	function automatic sct_pkg::sct_phase_t info_ph(input logic [2:0] m);
		unique case (m)
			sct_pkg::IP_DOUT: info_ph = sct_pkg::ph_data_out;
			sct_pkg::IP_DIN: info_ph = sct_pkg::ph_data_in;
			sct_pkg::IP_CMD: info_ph = sct_pkg::ph_command;
			sct_pkg::IP_STAT: info_ph = sct_pkg::ph_status;
			sct_pkg::IP_MOUT: info_ph = sct_pkg::message_out_phase;
			sct_pkg::IP_MIN: info_ph = sct_pkg::message_in_phase;
			default: info_ph = sct_pkg::ph_reserved;
		endcase
	endfunction

	// First cycle of a given phase
	function automatic logic starts(input sct_pkg::sct_phase_t p, input sct_pkg::sct_phase_t c,
		input sct_pkg::sct_phase_t q);
		starts = (c == p) && (q != p);
	endfunction

	// Phase decode
	assign bsy = bus.ctl[sct_pkg::CB_BSY];
	assign sel = bus.ctl[sct_pkg::CB_SEL];
	assign io = bus.ctl[sct_pkg::CB_IO];
	assign cur_ph = (!bsy && !sel) ? sct_pkg::ph_bus_free :
		sel ? (io ? sct_pkg::ph_reselection : sct_pkg::ph_selection) :
		nxt_arb_win ? sct_pkg::ph_arbitration :
		info_ph({bus.ctl[sct_pkg::CB_MSG], bus.ctl[sct_pkg::CB_CD], io});
	assign nxt_arb_win = (!bsy && !sel) ? 1'b1 :
		(prev_ff[9 + sct_pkg::CB_SEL] && !sel) ? 1'b0 : arb_win_ff;

	// Outputs toward capture and trigger
	assign bus.phase = cur_ph;
	assign bus.chg = {bus.ctl, bus.dat} != prev_ff;
	assign bus.byte_stb = bus.ctl[sct_pkg::CB_ACK] && !prev_ff[9 + sct_pkg::CB_ACK];
	assign bus.arb_start = starts(sct_pkg::ph_arbitration, cur_ph, prev_ph_ff);
	assign bus.sel_start = starts(sct_pkg::ph_selection, cur_ph, prev_ph_ff);
	assign bus.resel_start = starts(sct_pkg::ph_reselection, cur_ph, prev_ph_ff);

	// Previous line and phase state
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prev_ff <= '0;
			arb_win_ff <= 1'b0;
			prev_ph_ff <= sct_pkg::ph_bus_free;
		end else if (clk_en) begin
			prev_ff <= {bus.ctl, bus.dat};
			arb_win_ff <= nxt_arb_win;
			prev_ph_ff <= cur_ph;
		end
	end
endmodule

// ### core/sct_trig.sv
// Purpose: Trigger condition matcher with occurrence counter
// Assumes: cfg is the copy latched at capture start
// Notes: hit is a one-cycle pulse, only while armed
`timescale 1ns/1ps
module sct_trig (
	input logic sys_clk, // System clock
	input logic rst_b, // Sync reset, active low
	input logic clk_en, // Freezes state when low
	sct_bus_if.trg bus, // Decoded bus view
	input logic start, // First cycle of a capture
	input logic armed, // Running and not yet triggered
	input sct_pkg::sct_cfg_t cfg, // Active trigger settings
	output logic hit // Trigger fires
);
	logic [15:0] occ_ff;
	logic pat_ok;
	logic byte_ok;
	logic cond;
	logic reached;
	sct_pkg::sct_phase_t want;

	// Phase wanted by a byte transfer trigger
	always_comb begin
		unique case (cfg.tt)
			sct_pkg::TT_MOUT: want = sct_pkg::message_out_phase;
			sct_pkg::TT_CMD: want = sct_pkg::ph_command;
			sct_pkg::TT_DOUT: want = sct_pkg::ph_data_out;
			sct_pkg::TT_DIN: want = sct_pkg::ph_data_in;
			sct_pkg::TT_STAT: want = sct_pkg::ph_status;
			sct_pkg::TT_MIN: want = sct_pkg::message_in_phase;
			default: want = sct_pkg::ph_reserved;
		endcase
	end

	// Condition select; an unknown type never matches
	assign pat_ok = ((bus.dat ^ cfg.val) & cfg.care) == '0;
	assign byte_ok = (want != sct_pkg::ph_reserved) && bus.byte_stb && (bus.phase == want) && pat_ok;
	assign cond = (cfg.tt == sct_pkg::TT_ARB) ? bus.arb_start :
		(cfg.tt == sct_pkg::TT_SEL) ? bus.sel_start :
		(cfg.tt == sct_pkg::TT_RESEL) ? bus.resel_start : byte_ok;
	assign reached = (17'(occ_ff) + 17'h00001) >= 17'(cfg.cnt);
	assign hit = (cfg.tt == sct_pkg::TT_IMMED) ? (start && armed) : (armed && cond && reached);

	// Occurrence counter, cleared per capture
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			occ_ff <= '0;
		end else if (clk_en) begin
			if (start) begin
				occ_ff <= '0;
			end else if (armed && cond && occ_ff != '1) begin
				occ_ff <= occ_ff + 16'h0001;
			end
		end
	end
endmodule

// ### tb/sct_chk.sv
// Purpose: Bus handshake and readback checks on the capture top
// Assumes: One sys_clk domain, clk_en as the only stall source besides reads
// Notes: Watches ports only, bound to every capture top
`timescale 1ns/1ps
module sct_chk (
	input wire logic sys_clk, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic clk_en, // Enable
	input wire logic [3:0] avs_address, // Word index
	input wire logic avs_read, // Read
	input wire logic avs_write, // Write
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest, // Stall
	input wire logic irq // Interrupt
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// A read completes at the edge where the stall is low
	wire logic rd_done = avs_read & !avs_waitrequest;
	a_stall_when_off: assert property (!clk_en |-> avs_waitrequest) else $error("no stall while frozen");
	a_write_no_wait: assert property (clk_en && avs_write |-> !avs_waitrequest) else $error("write stalled");
	a_read_one_wait: assert property (clk_en && avs_read && !$past(avs_read) |-> avs_waitrequest ##1
		(!avs_waitrequest || !clk_en)) else $error("read wait state wrong");
	a_rdata_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata)) else $error("read data moved");
	a_status_code: assert property (rd_done && avs_address == sct_pkg::REG_STATUS |->
		avs_readdata[31:2] == 30'h0) else $error("status out of range");
	a_count_range: assert property (rd_done && avs_address == sct_pkg::REG_TCOUNT |->
		avs_readdata[31:16] == 16'h0) else $error("count out of range");
	a_limit_range: assert property (rd_done && avs_address == sct_pkg::REG_QLIMIT |->
		avs_readdata >= 32'h1 && avs_readdata <= 32'hEFFF) else $error("limit out of range");
	a_unmapped_zero: assert property (rd_done && avs_address == 4'hF |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	// Interrupt only drops after an interrupt status read or a mask write
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(avs_read || avs_write)) else $error("irq dropped");
	c_irq: cover property (irq);
	c_status: cover property (rd_done && avs_address == sct_pkg::REG_STATUS);
	c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind sct_top sct_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq));

// ### tb/sct_scsi_model.sv
// Purpose: Behavioural initiator and target on the monitored lines
// Assumes: 1 = asserted, released lines read deasserted
// Notes: Each step lasts several clocks so the pin synchroniser sees it
`timescale 1ns/1ps
module sct_scsi_model (
	input wire logic sys_clk, // Clock
	output logic [8:0] ctl, // Control lines
	output logic [8:0] dat // Parity and data
);
	initial begin
		ctl = 9'h000;
		dat = 9'h000;
	end
	// One bus state held for n clocks
	task automatic hold(input logic [8:0] c, input logic [8:0] d, input int n);
		ctl <= c;
		dat <= d;
		repeat (n) @(posedge sys_clk);
	endtask
	// Bus free, arbitration, selection, then target holds the bus
	task automatic select();
		hold(9'h000, 9'h000, 4);
		hold(9'h100, 9'h080, 4);
		hold(9'h180, 9'h081, 4);
		hold(9'h100, 9'h000, 4);
	endtask
	// Byte handshakes in one phase; data is not held after ACK drops
	task automatic xfer(input logic [2:0] ph, input logic [7:0] b, input int n);
		logic [8:0] c;
		logic [8:0] d;
		c = {1'b1, 4'h0, ph[1], ph[0], ph[2], 1'b0};
		d = {~^b, b};
		for (int i = 0; i < n; i++) begin
			hold(c | 9'h020, d, 3);
			hold(c | 9'h030, d, 3);
			hold(c | 9'h010, d, 3);
			hold(c, ~d, 3);
		end
	endtask
endmodule

// ### tb/sct_top_tb_top.sv
// Purpose: Self-checking bench for the capture and trigger top
// Assumes: clk_en mostly high, bus lines from the behavioural model
// Notes: Full capture uses the small post share to stay short
`timescale 1ns/1ps
module sct_top_tb_top;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [8:0] ctl;
	logic [8:0] dat;
	logic irq;
	int n_errors = 0;
	int num_checks = 0;
	always #12.5 sys_clk = ~sys_clk;
	sct_scsi_model bus (.sys_clk(sys_clk), .ctl(ctl), .dat(dat));
	sct_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .scsi_ctl_in(ctl), .scsi_dat_in(dat), .irq(irq));
	// Bus cycles hold until the stall clears, then release one edge later
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic cmp(input string s, input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] v;
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
		@(posedge sys_clk);
		cmp($sformatf("reg %0h", a), v, e);
	endtask
	task automatic t_defaults();
		wr(sct_pkg::REG_IRQ_MASK, 32'h0);
		clk_en <= 1'b0;
		@(posedge sys_clk);
		cmp("stall", {31'h0, avs_waitrequest}, 32'h1);
		clk_en <= 1'b1;
		chk(sct_pkg::REG_STATUS, {30'h0, sct_pkg::ST_IDLE});
		chk(sct_pkg::REG_TTYPE, 32'h1);
		chk(sct_pkg::REG_TPAT, 32'h0);
		chk(sct_pkg::REG_TCOUNT, 32'h1);
		chk(sct_pkg::REG_TPLACE, 32'h0);
		chk(sct_pkg::REG_QMODE, 32'h0);
		chk(sct_pkg::REG_QLIMIT, 32'h8000);
		chk(4'hF, 32'h0);
	endtask
	task automatic t_bad();
		for (int k = 0; k < 11; k++) begin
			wr(sct_pkg::REG_TTYPE, k);
			chk(sct_pkg::REG_TTYPE, k);
		end
		wr(sct_pkg::REG_TCOUNT, 32'h5);
		wr(sct_pkg::REG_TPAT, 32'h0001_0000);
		chk(sct_pkg::REG_TTYPE, 32'h1);
		chk(sct_pkg::REG_TCOUNT, 32'h1);
		wr(sct_pkg::REG_TPLACE, 32'h1);
		wr(sct_pkg::REG_TTYPE, 32'hB);
		chk(sct_pkg::REG_TPLACE, 32'h0);
		wr(sct_pkg::REG_QMODE, 32'h2);
		wr(sct_pkg::REG_QLIMIT, 32'h0);
		chk(sct_pkg::REG_QMODE, 32'h0);
		wr(sct_pkg::REG_QLIMIT, 32'hEFFF);
		chk(sct_pkg::REG_QLIMIT, 32'hEFFF);
	endtask
	// Third command byte fires; the interrupt stays masked
	task automatic t_count();
		wr(sct_pkg::REG_TTYPE, 32'h6);
		wr(sct_pkg::REG_TCOUNT, 32'h3);
		wr(sct_pkg::REG_CTRL, 32'h1);
		bus.select();
		bus.xfer(sct_pkg::IP_CMD, 8'h12, 2);
		chk(sct_pkg::REG_STATUS, {30'h0, sct_pkg::ST_WAIT});
		bus.xfer(sct_pkg::IP_CMD, 8'h34, 1);
		chk(sct_pkg::REG_STATUS, {30'h0, sct_pkg::ST_TRIG});
		cmp("irq", {31'h0, irq}, 32'h0);
		wr(sct_pkg::REG_CTRL, 32'h2);
		chk(sct_pkg::REG_STATUS, {30'h0, sct_pkg::ST_IDLE});
	endtask
	// Trigger near the end leaves a short post share, so the buffer fills
	task automatic t_full();
		wr(sct_pkg::REG_TTYPE, 32'h1);
		wr(sct_pkg::REG_TPLACE, 32'h2);
		wr(sct_pkg::REG_IRQ_MASK, 32'h3);
		wr(sct_pkg::REG_CTRL, 32'h1);
		wr(sct_pkg::REG_TPLACE, 32'h0);
		bus.xfer(sct_pkg::IP_DIN, 8'h5A, 20);
		chk(sct_pkg::REG_STATUS, {30'h0, sct_pkg::ST_FULL});
		cmp("irq", {31'h0, irq}, 32'h1);
		chk(sct_pkg::REG_IRQ_ST, 32'h3);
		cmp("irq", {31'h0, irq}, 32'h0);
	endtask
	task automatic final_report();
		if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_defaults();
		t_bad();
		t_count();
		t_full();
		final_report();
	end
	// Whole run needs well under a tenth of this span
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		final_report();
	end
endmodule
